// *** src/fod_core.sv ***
// Decode and execute slice for watchdog clear, complement and decrement-skip.
//
// The implementer's own choices: the register addresses and strobed register access.

//
// Function
// - Complement inverts every bit of the file register and sets zero flag.
// - Complement result goes to working register if d is 0, else file.
// - Decrement-skip subtracts one and leaves the zero, timeout and powerdown flags untouched; it sets skipPending.
// - Decrement-skip result goes to working register if d is 0, else file.
// - Zero result turns the fetched next instruction into a no-operation.
// - Nonzero result lets the next instruction run; one cycle only.
// - Four phases: decode, read, process, write; a skipped cycle does nothing.
module fod_core
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Fetched instruction
  input wire logic [13:0] instrWord,
  // Register file
  output logic [6:0] fileAddr,
  input wire logic [7:0] fileRdData,
  output logic [7:0] fileWrData,
  output logic fileWrEn,
  // Core state
  output logic [7:0] workReg,
  output logic zeroFlag,
  output logic timeout_flag,
  output logic powerdown_flag,
  output logic skipCycle,
  output logic [7:0] watchdog_counter,
  output logic [7:0] watchdogPrescale,
  output logic watchdogClear,
  // Register port
  input wire logic [1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrStrobe,
  input wire logic regRdStrobe,
  output logic [7:0] regRdData
);

  typedef struct packed {
    logic run;
    logic [13:0] instr;
    logic nopCycle;
    logic skipPending;
    logic [7:0] operand;
    logic [7:0] result;
    logic [6:0] fileAddr;
    logic [7:0] fileWrData;
    logic fileWrEn;
    logic [7:0] workReg;
    logic zeroFlag;
    logic timeout;
    logic powerdown;
    logic [7:0] watchCount;
    logic [7:0] watchPre;
    logic watchClr;
    logic [7:0] rdData;
  } fod_core_state_t;

  fod_core_state_t r;
  fod_core_state_t n;

  // ----------------------------------------
  // Phase carrier
  // ----------------------------------------
  // The sequencer only advances while run is set, so stopping freezes the current phase.
  fod_phase_if ph ();

  fod_phase_seq u_seq
  (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .ph(ph.seq)
  );

  // ----------------------------------------
  // Decoding
  // ----------------------------------------
  function automatic logic fod_is_op(input logic [13:0] ins, input logic [5:0] op);
    fod_is_op = (ins[fod_pkg::OP_HI:fod_pkg::OP_LO] == op);
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    n = r;
    n.fileWrEn = 1'b0;
    n.watchClr = 1'b0;
    n.rdData = 8'h00;
    // The watchdog keeps counting between clears; the prescaler feeds it.
    n.watchPre = r.watchPre + 8'h01;
    if (r.watchPre == 8'hff)
    begin
      n.watchCount = r.watchCount + 8'h01;
    end
    if (regWrStrobe && regAddr == fod_pkg::ADR_CTRL)
    begin
      n.run = regWrData[fod_pkg::CTRL_RUN_BIT];
    end
    if (regRdStrobe)
    begin
      case (regAddr)
        fod_pkg::ADR_CTRL: n.rdData = {7'h00, r.run};
        fod_pkg::ADR_STATUS: n.rdData = {3'h0, r.nopCycle, r.skipPending, r.timeout, r.powerdown, r.zeroFlag};
        fod_pkg::ADR_WORK: n.rdData = r.workReg;
        fod_pkg::ADR_WATCH: n.rdData = r.watchCount;
        default: n.rdData = 8'h00;
      endcase
    end
    if (r.run)
    begin
      case (ph.phase)
        fod_pkg::PH_Q1:
        begin
          // A pending skip replaces this fetched word by a no-operation.
          n.instr = instrWord;
          n.nopCycle = r.skipPending;
          n.skipPending = 1'b0;
          n.fileAddr = instrWord[fod_pkg::ADDR_HI:0];
        end
        fod_pkg::PH_Q2:
        begin
          n.operand = fileRdData;
        end
        fod_pkg::PH_Q3:
        begin
          if (fod_is_op(r.instr, fod_pkg::OP_COMPL))
          begin
            n.result = ~r.operand;
          end
          else
          begin
            n.result = r.operand - 8'h01;
          end
        end
        fod_pkg::PH_Q4:
        begin
          if (!r.nopCycle)
          begin
            if (fod_is_op(r.instr, fod_pkg::OP_COMPL) || fod_is_op(r.instr, fod_pkg::OP_DECSKIP))
            begin
              if (r.instr[fod_pkg::DEST_BIT])
              begin
                n.fileWrEn = 1'b1;
                n.fileWrData = r.result;
              end
              else
              begin
                n.workReg = r.result;
              end
            end
            if (fod_is_op(r.instr, fod_pkg::OP_COMPL))
            begin
              n.zeroFlag = (r.result == 8'h00);
            end
            if (fod_is_op(r.instr, fod_pkg::OP_DECSKIP))
            begin
              n.skipPending = (r.result == 8'h00);
            end
            // The clear is placed after the free-running count so that it wins in the same cycle.
            // No timeout action exists here; the flags are set only by reset and by this instruction.
            if (r.instr == fod_pkg::OP_WATCH_CLEAR)
            begin
              n.watchCount = 8'h00;
              n.watchPre = 8'h00;
              n.watchClr = 1'b1;
              n.timeout = 1'b1;
              n.powerdown = 1'b1;
            end
          end
        end
        default:
        begin
          n.nopCycle = r.nopCycle;
        end
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      r <= '0;
      r.run <= fod_pkg::RST_RUN;
      r.timeout <= fod_pkg::RST_TIMEOUT;
      r.powerdown <= fod_pkg::RST_POWERDOWN;
      r.workReg <= fod_pkg::RST_WORK;
    end
    else
    begin
      r <= n;
    end
  end

  assign ph.run = r.run;

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign fileAddr = r.fileAddr;
  assign fileWrData = r.fileWrData;
  assign fileWrEn = r.fileWrEn;
  assign workReg = r.workReg;
  assign zeroFlag = r.zeroFlag;
  assign timeout_flag = r.timeout;
  assign powerdown_flag = r.powerdown;
  assign skipCycle = r.nopCycle;
  assign watchdog_counter = r.watchCount;
  assign watchdogPrescale = r.watchPre;
  assign watchdogClear = r.watchClr;
  assign regRdData = r.rdData;

endmodule

// *** src/fod_phase_if.sv ***
// Carrier for the instruction phase between sequencer and core.
interface fod_phase_if;
  logic run;
  fod_pkg::fod_phase_t phase;

  modport seq
  (
    input run,
    output phase
  );

  modport core
  (
    output run,
    input phase
  );
endinterface

// *** src/fod_phase_seq.sv ***
// Four-phase sequencer for the instruction cycle.
module fod_phase_seq
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Phase carrier
  fod_phase_if.seq ph
);

  typedef struct packed {
    fod_pkg::fod_phase_t phase;
  } fod_seq_state_t;

  fod_seq_state_t r;
  fod_seq_state_t n;

  always_comb
  begin
    n = r;
    if (ph.run)
    begin
      case (r.phase)
        fod_pkg::PH_Q1: n.phase = fod_pkg::PH_Q2;
        fod_pkg::PH_Q2: n.phase = fod_pkg::PH_Q3;
        fod_pkg::PH_Q3: n.phase = fod_pkg::PH_Q4;
        fod_pkg::PH_Q4: n.phase = fod_pkg::PH_Q1;
        default: n.phase = fod_pkg::PH_Q1;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      r.phase <= fod_pkg::PH_Q1;
    end
    else
    begin
      r <= n;
    end
  end

  assign ph.phase = r.phase;

endmodule

// *** src/fod_pkg.sv ***
// Shared constants and types for the file operation decode slice.
package fod_pkg;

  // ----------------------------------------
  // Instruction encodings
  // ----------------------------------------
  localparam logic [13:0] OP_WATCH_CLEAR = 14'h0064;
  localparam logic [5:0] OP_COMPL = 6'h09;
  localparam logic [5:0] OP_DECSKIP = 6'h0b;
  localparam int OP_HI = 13;
  localparam int OP_LO = 8;
  localparam int DEST_BIT = 7;
  localparam int ADDR_HI = 6;

  // ----------------------------------------
  // Register port map
  // ----------------------------------------
  localparam logic [1:0] ADR_CTRL = 2'h0;
  localparam logic [1:0] ADR_STATUS = 2'h1;
  localparam logic [1:0] ADR_WORK = 2'h2;
  localparam logic [1:0] ADR_WATCH = 2'h3;
  localparam int CTRL_RUN_BIT = 0;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic RST_RUN = 1'b0;
  localparam logic RST_TIMEOUT = 1'b1;
  localparam logic RST_POWERDOWN = 1'b1;
  localparam logic [7:0] RST_WORK = 8'h00;

  // ----------------------------------------
  // Clock phases of one instruction cycle
  // ----------------------------------------
  localparam int PHASE_COUNT = 4;
  typedef enum logic [3:0] {
    PH_Q1 = 4'b0001,
    PH_Q2 = 4'b0010,
    PH_Q3 = 4'b0100,
    PH_Q4 = 4'b1000
  } fod_phase_t;

endpackage

// *** tb/fod_core_monitor.sv ***
// Assertion checker for the file operation decode slice.
module fod_core_monitor
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Observed ports
  input wire logic [13:0] instrWord,
  input wire logic [6:0] fileAddr,
  input wire logic [7:0] fileWrData,
  input wire logic fileWrEn,
  input wire logic zeroFlag,
  input wire logic timeout_flag,
  input wire logic powerdown_flag,
  input wire logic skipCycle,
  input wire logic [7:0] watchdog_counter,
  input wire logic [7:0] watchdogPrescale,
  input wire logic watchdogClear
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  // The instruction is taken four ticks before its write, so depth 4 points back at the Q1 edge.
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wr_pulse_one_a: assert property (fileWrEn |=> !fileWrEn)
    else $error("write pulse too long");
  wr_dest_bit_a: assert property (fileWrEn |-> $past(instrWord[fod_pkg::DEST_BIT], 4))
    else $error("file write with d clear");
  wr_addr_a: assert property (fileWrEn |-> fileAddr == $past(instrWord[6:0], 4))
    else $error("file write address wrong");
  compl_zero_a: assert property (fileWrEn && $past(instrWord[13:8], 4) == fod_pkg::OP_COMPL
    |-> zeroFlag == (fileWrData == 8'h00)) else $error("zero flag wrong");
  zero_only_compl_a: assert property ($changed(zeroFlag)
    |-> $past(instrWord[13:8], 4) == fod_pkg::OP_COMPL) else $error("zero flag moved");
  skip_decide_a: assert property (fileWrEn && $past(instrWord[13:8], 4) == fod_pkg::OP_DECSKIP
    |=> skipCycle == ($past(fileWrData) == 8'h00)) else $error("skip decision wrong");
  skip_len_a: assert property ($rose(skipCycle) |-> skipCycle [*4] ##1 !skipCycle)
    else $error("skip length wrong");
  skip_quiet_a: assert property (skipCycle |-> !fileWrEn && !watchdogClear)
    else $error("skipped cycle acted");
  clear_zeroes_a: assert property (watchdogClear |-> watchdog_counter == 8'h00
    && watchdogPrescale == 8'h00 && timeout_flag && powerdown_flag) else $error("clear incomplete");
endmodule

bind fod_core fod_core_monitor u_mon (.ref_clk, .sys_rst, .instrWord, .fileAddr, .fileWrData, .fileWrEn,
  .zeroFlag, .timeout_flag, .powerdown_flag, .skipCycle, .watchdog_counter, .watchdogPrescale, .watchdogClear);

// *** tb/fod_core_tb.sv ***
// Self-checking testbench for the file operation decode slice.
module fod_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [13:0] instrWord = 14'h0000;
  logic [6:0] fileAddr;
  logic [7:0] fileRdData, fileWrData, workReg, watchdog_counter, watchdogPrescale, regRdData;
  logic fileWrEn, zeroFlag, timeout_flag, powerdown_flag, skipCycle, watchdogClear;
  logic [1:0] regAddr = 2'h0;
  logic [7:0] regWrData = 8'h00;
  logic regWrStrobe = 1'b0;
  logic regRdStrobe = 1'b0;
  logic [7:0] fmem [128];
  int emem [128];
  int w, z, skip, sk, wr, a, d, op, r, miscompares, num_checks;
  fod_core dut (.*);
  always #20 ref_clk = ~ref_clk;
  assign fileRdData = fmem[fileAddr];
  always @(posedge ref_clk) if (fileWrEn) fmem[fileAddr] <= fileWrData;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input int exp);
    num_checks++;
    if (got !== exp[7:0])
    begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp[7:0]);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic reg_wr(input logic [1:0] ad, input logic [7:0] dt);
    regAddr <= ad;
    regWrData <= dt;
    regWrStrobe <= 1'b1;
    @(posedge ref_clk);
    regWrStrobe <= 1'b0;
  endtask
  task automatic reg_rd(input logic [1:0] ad, input int exp);
    regAddr <= ad;
    regRdStrobe <= 1'b1;
    @(posedge ref_clk);
    regRdStrobe <= 1'b0;
    #1 chk(regRdData, exp);
  endtask
  // Small addresses and values near zero make skips, and chained skips, common.
  task automatic exec();
    op = $urandom % 4;
    a = $urandom % 8;
    d = $urandom % 2;
    instrWord <= (op == 0) ? fod_pkg::OP_WATCH_CLEAR : {op == 1 ? fod_pkg::OP_COMPL :
      op == 2 ? fod_pkg::OP_DECSKIP : 6'h0e, d[0], a[6:0]};
    @(posedge ref_clk);
    reg_rd(fod_pkg::ADR_WORK, w);
    repeat (2) @(posedge ref_clk);
    #1;
    sk = skip;
    wr = 0;
    skip = 0;
    if (sk == 0 && (op == 1 || op == 2))
    begin
      r = (op == 1) ? ~emem[a] & 255 : (emem[a] + 255) % 256;
      if (op == 1) z = (r == 0);
      if (op == 2) skip = (r == 0);
      if (d != 0) emem[a] = r;
      else w = r;
      wr = d;
    end
    chk({7'h00, skipCycle}, sk);
    chk({7'h00, fileWrEn}, wr);
    if (wr != 0) chk(fileWrData, r);
    chk(workReg, w);
    chk({7'h00, zeroFlag}, z);
    chk({7'h00, watchdogClear}, op == 0 && sk == 0);
    if (op == 0 && sk == 0) chk(watchdog_counter | watchdogPrescale, 0);
    chk({6'h00, timeout_flag, powerdown_flag}, 3);
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    #1ms;
    miscompares++;
    wrap_up();
  end
  initial
  begin
    void'($urandom(32'h64622528));
    for (int i = 0; i < 128; i++)
    begin
      emem[i] = ($urandom % 4 == 0) ? 255 : $urandom % 3;
      fmem[i] = emem[i][7:0];
    end
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    reg_rd(fod_pkg::ADR_CTRL, 0);
    reg_wr(fod_pkg::ADR_WORK, 8'haa);
    reg_rd(fod_pkg::ADR_WORK, 0);
    reg_rd(fod_pkg::ADR_STATUS, 8'h06);
    reg_rd(fod_pkg::ADR_WATCH, 0);
    reg_wr(fod_pkg::ADR_CTRL, 8'h01);
    repeat (200) exec();
    wrap_up();
  end
endmodule
